// ---- core/smo_pkg.sv ----
// constants for the supply monitor, oscillator and regulator register bank
//
// Behaviour
// - supply-low flag shows a pending monitor interrupt
// - writing one clears flag; zero leaves it
// - enable bit gates the monitor interrupt
// - flag/enable behave like other transceiver sources
// - above-threshold bit shows comparator status, read-only
// - range bit selects low or high range
// - threshold code maps to range voltages
// - oscillator mode resets to normal crystal operation
// - mode codes select external reference or crystal
// - load-trim code selects capacitance steps
// - bypass bit stored only, regulator stays on
// - settled flag reads one when bypass set
// - else settled flag follows regulator settled input
// - core trim field stored and driven out
// - flag clears when service routine starts
`default_nettype none
package smo_pkg;
  // ---------------------------------------------------------------
  // register byte addresses (index times four)
  // ---------------------------------------------------------------
  localparam logic [11:0] SMO_IDX_MON = 12'h151;
  localparam logic [11:0] SMO_IDX_OSC = 12'h152;
  localparam logic [11:0] SMO_IDX_REG = 12'h150;
  localparam logic [11:0] SMO_IDX_IRQ = 12'h160;
  localparam logic [11:0] SMO_IDX_MSK = 12'h161;
  localparam logic [13:0] SMO_ADDR_MON = {SMO_IDX_MON, 2'b00};
  localparam logic [13:0] SMO_ADDR_OSC = {SMO_IDX_OSC, 2'b00};
  localparam logic [13:0] SMO_ADDR_REG = {SMO_IDX_REG, 2'b00};
  localparam logic [13:0] SMO_ADDR_IRQ = {SMO_IDX_IRQ, 2'b00};
  localparam logic [13:0] SMO_ADDR_MSK = {SMO_IDX_MSK, 2'b00};
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SMO_MON_FLAG = 7;
  localparam int SMO_MON_EN = 6;
  localparam int SMO_MON_OK = 5;
  localparam int SMO_MON_HR = 4;
  localparam int SMO_REG_BYP = 3;
  localparam int SMO_REG_SET = 2;
  // ---------------------------------------------------------------
  // reset values and codes
  // ---------------------------------------------------------------
  localparam logic [3:0] SMO_VTH_RST = 4'h2;
  localparam logic [3:0] SMO_MODE_RST = 4'hf;
  localparam logic [3:0] SMO_MODE_EXT = 4'h4;
  localparam logic [3:0] SMO_MODE_XTAL = 4'hf;
  localparam logic [3:0] SMO_TRIM_RST = 4'h0;
  localparam logic [1:0] SMO_CTRIM_RST = 2'h0;
  localparam logic [1:0] SMO_RESP_OKAY = 2'b00;
  localparam logic [1:0] SMO_RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

// ---- core/smo_regs.sv ----
// register bank for supply monitor, crystal oscillator and core regulator
`default_nettype none
module smo_regs
  import smo_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analog side, asynchronous inputs
  input wire logic supply_above_threshold_in,
  input wire logic core_supply_settled_in,
  // analog side controls
  output logic monitor_high_range,
  output logic [3:0] monitor_threshold_code,
  output logic [3:0] osc_mode,
  output logic osc_crystal_enable,
  output logic osc_external_ref,
  output logic [3:0] osc_load_trim,
  output logic [1:0] core_supply_trim,
  // interrupt
  input wire logic isr_enter,
  output logic monitor_irq,
  output logic irq
);

  typedef struct packed {
    logic aw_got;
    logic [13:0] aw_addr;
    logic w_got;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic ok_s1;
    logic ok_s2;
    logic ok_prev;
    logic set_s1;
    logic set_s2;
    logic flag;
    logic en;
    logic hr;
    logic [3:0] vth;
    logic [3:0] mode;
    logic [3:0] trim;
    logic bypass;
    logic [1:0] ctrim;
    logic irq_st;
    logic irq_msk;
  } smo_state_t;

  smo_state_t st_reg;
  smo_state_t st_next;
  logic fall;
  logic do_write;
  logic wr_lane;
  logic [7:0] mon_view;
  logic [7:0] reg_view;

  // ---------------------------------------------------------------
  // read decode
  // ---------------------------------------------------------------
  // settled flag is forced high by bypass, regardless of regulator
  function automatic logic [7:0] smo_read(input logic [13:0] a, input smo_state_t s);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      SMO_ADDR_MON: v = {s.flag, s.en, s.ok_s2, s.hr, s.vth};
      SMO_ADDR_OSC: v = {s.mode, s.trim};
      SMO_ADDR_REG: v = {4'h0, s.bypass, s.bypass | s.set_s2, s.ctrim};
      SMO_ADDR_IRQ: v = {7'h00, s.irq_st};
      SMO_ADDR_MSK: v = {7'h00, s.irq_msk};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  function automatic logic smo_mapped(input logic [13:0] a);
    return (a == SMO_ADDR_MON) || (a == SMO_ADDR_OSC) || (a == SMO_ADDR_REG) ||
           (a == SMO_ADDR_IRQ) || (a == SMO_ADDR_MSK);
  endfunction

  assign fall = st_reg.ok_prev & ~st_reg.ok_s2;
  assign do_write = st_reg.aw_got & st_reg.w_got & ~st_reg.bvalid;
  assign wr_lane = do_write & st_reg.w_lane0 & smo_mapped(st_reg.aw_addr);
  // software views of the two mixed registers, watched by the checks below
  assign mon_view = smo_read(SMO_ADDR_MON, st_reg);
  assign reg_view = smo_read(SMO_ADDR_REG, st_reg);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // two-flop synchronisers; first stage read only by second
    st_next.ok_s1 = supply_above_threshold_in;
    st_next.ok_s2 = st_reg.ok_s1;
    st_next.ok_prev = st_reg.ok_s2;
    st_next.set_s1 = core_supply_settled_in;
    st_next.set_s2 = st_reg.set_s1;
    // channel capture; one write outstanding at a time
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_got = 1'b1;
      st_next.aw_addr = s_axi_awaddr[13:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_got = 1'b1;
      st_next.w_data = s_axi_wdata[7:0];
      st_next.w_lane0 = s_axi_wstrb[0];
    end
    if (do_write) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = smo_mapped(st_reg.aw_addr) ? SMO_RESP_OKAY : SMO_RESP_SLVERR;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    // register writes
    if (wr_lane) begin
      case (st_reg.aw_addr)
        SMO_ADDR_MON: begin
          if (st_reg.w_data[SMO_MON_FLAG]) begin
            st_next.flag = 1'b0;
          end
          st_next.en = st_reg.w_data[SMO_MON_EN];
          st_next.hr = st_reg.w_data[SMO_MON_HR];
          st_next.vth = st_reg.w_data[3:0];
        end
        SMO_ADDR_OSC: begin
          st_next.mode = st_reg.w_data[7:4];
          st_next.trim = st_reg.w_data[3:0];
        end
        SMO_ADDR_REG: begin
          st_next.bypass = st_reg.w_data[SMO_REG_BYP];
          st_next.ctrim = st_reg.w_data[1:0];
        end
        SMO_ADDR_IRQ: begin
          if (st_reg.w_data[0]) begin
            st_next.irq_st = 1'b0;
          end
        end
        SMO_ADDR_MSK: begin
          st_next.irq_msk = st_reg.w_data[0];
        end
        default: begin
          st_next.irq_msk = st_reg.irq_msk;
        end
      endcase
    end
    // service entry clears, like the other transceiver flags
    if (isr_enter) begin
      st_next.flag = 1'b0;
    end
    // a falling comparator wins over any clear in the same cycle
    if (fall) begin
      st_next.flag = 1'b1;
      st_next.irq_st = 1'b1;
    end
    // read channel
    if (s_axi_arvalid && s_axi_arready) begin
      st_next.rvalid = 1'b1;
      st_next.rdata = smo_read(s_axi_araddr[13:0], st_reg);
      st_next.rresp = smo_mapped(s_axi_araddr[13:0]) ? SMO_RESP_OKAY : SMO_RESP_SLVERR;
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.vth <= SMO_VTH_RST;
      st_reg.mode <= SMO_MODE_RST;
      st_reg.trim <= SMO_TRIM_RST;
      st_reg.ctrim <= SMO_CTRIM_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign s_axi_awready = ~st_reg.aw_got & ~st_reg.bvalid;
  assign s_axi_wready = ~st_reg.w_got & ~st_reg.bvalid;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = ~st_reg.rvalid;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = {24'h000000, st_reg.rdata};
  assign s_axi_rresp = st_reg.rresp;
  assign monitor_high_range = st_reg.hr;
  assign monitor_threshold_code = st_reg.vth;
  assign osc_mode = st_reg.mode;
  // other mode codes keep the crystal running without regulation choice
  assign osc_external_ref = (st_reg.mode == SMO_MODE_EXT);
  assign osc_crystal_enable = (st_reg.mode != SMO_MODE_EXT);
  assign osc_load_trim = st_reg.trim;
  assign core_supply_trim = st_reg.ctrim;
  assign monitor_irq = st_reg.flag & st_reg.en;
  assign irq = st_reg.irq_st & st_reg.irq_msk;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_FALL_SETS: assert property (@(posedge aclk) disable iff (!aresetn)
    fall |=> st_reg.flag)
    else $error("falling comparator did not set flag");
  AST_IRQ_AND: assert property (@(posedge aclk) disable iff (!aresetn)
    monitor_irq == (st_reg.flag && st_reg.en))
    else $error("monitor irq not flag and enable");
  AST_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_lane && st_reg.aw_addr == SMO_ADDR_MON && st_reg.w_data[SMO_MON_FLAG] && !fall)
    |=> !st_reg.flag)
    else $error("write one did not clear flag");
  AST_ISR: assert property (@(posedge aclk) disable iff (!aresetn)
    (isr_enter && !fall) |=> !st_reg.flag)
    else $error("service entry did not clear flag");
  AST_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (!fall && !isr_enter && !wr_lane) |=> st_reg.flag == $past(st_reg.flag))
    else $error("flag changed without cause");
  AST_EN_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
    !st_reg.en |-> !monitor_irq)
    else $error("irq raised while disabled");
  AST_EXT_MODE: assert property (@(posedge aclk) disable iff (!aresetn)
    (osc_mode == SMO_MODE_EXT) |-> (osc_external_ref && !osc_crystal_enable))
    else $error("external mode decode wrong");
  AST_RST_MODE: assert property (@(posedge aclk)
    !aresetn |=> osc_mode == SMO_MODE_RST)
    else $error("mode reset value wrong");

  // ---------------------------------------------------------------
  // flag, status bit and interrupt checks
  // ---------------------------------------------------------------
  // a zero in the flag position must not disturb a pending flag
  AST_ZERO_KEEPS: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_lane && st_reg.aw_addr == SMO_ADDR_MON && !st_reg.w_data[SMO_MON_FLAG] &&
     !isr_enter && !fall) |=> st_reg.flag == $past(st_reg.flag))
    else $error("write of zero changed flag");

  // the shared status bit is set by the same event as the flag
  AST_IRQ_ST_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    fall |=> st_reg.irq_st)
    else $error("falling comparator did not set status");

  // the shared request is a plain level of status and mask
  AST_IRQ_LEVEL: assert property (@(posedge aclk) disable iff (!aresetn)
    irq == (st_reg.irq_st && st_reg.irq_msk))
    else $error("irq not status and mask");

  // above-threshold bit shows the synchronised comparator only
  AST_OK_VIEW: assert property (@(posedge aclk) disable iff (!aresetn)
    mon_view[SMO_MON_OK] == st_reg.ok_s2)
    else $error("status bit not comparator level");

  // flag bit seen by software is the pending flag itself
  AST_FLAG_VIEW: assert property (@(posedge aclk) disable iff (!aresetn)
    mon_view[SMO_MON_FLAG] == st_reg.flag)
    else $error("flag bit view wrong");

  // ---------------------------------------------------------------
  // regulator, oscillator and field reset checks
  // ---------------------------------------------------------------
  // bypass forces the settled view high whatever the regulator says
  AST_BYP_SETTLED: assert property (@(posedge aclk) disable iff (!aresetn)
    st_reg.bypass |-> reg_view[SMO_REG_SET])
    else $error("settled not forced by bypass");

  // without bypass the settled view follows the synchronised input
  AST_SETTLED_FOLLOWS: assert property (@(posedge aclk) disable iff (!aresetn)
    !st_reg.bypass |-> reg_view[SMO_REG_SET] == st_reg.set_s2)
    else $error("settled view not input");

  // bypass is only stored; it reads back what was written
  AST_BYP_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_lane && st_reg.aw_addr == SMO_ADDR_REG)
    |=> st_reg.bypass == $past(st_reg.w_data[SMO_REG_BYP]))
    else $error("bypass write lost");

  // crystal code keeps the oscillator on and the reference off
  AST_XTAL_MODE: assert property (@(posedge aclk) disable iff (!aresetn)
    (osc_mode == SMO_MODE_XTAL) |-> (osc_crystal_enable && !osc_external_ref))
    else $error("crystal mode decode wrong");

  // load trim changes only through an oscillator write
  AST_TRIM_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    !(wr_lane && st_reg.aw_addr == SMO_ADDR_OSC) |=> $stable(osc_load_trim))
    else $error("load trim changed without write");

  // core trim changes only through a regulator write
  AST_CTRIM_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    !(wr_lane && st_reg.aw_addr == SMO_ADDR_REG) |=> $stable(core_supply_trim))
    else $error("core trim changed without write");

  // threshold, load trim and core trim come out of reset at their documented values, no request
  AST_RST_FIELDS: assert property (@(posedge aclk)
    !aresetn |=> (monitor_threshold_code == SMO_VTH_RST && osc_load_trim == SMO_TRIM_RST &&
                  core_supply_trim == SMO_CTRIM_RST && !monitor_irq && !irq))
    else $error("field reset value wrong");

  // ---------------------------------------------------------------
  // bus checks
  // ---------------------------------------------------------------
  // a write answer stands with its code until the master takes it
  AST_B_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write response dropped early");

  // a read answer stands with its data until the master takes it
  AST_R_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)))
    else $error("read response dropped early");

  // no new write is taken while an answer is still pending
  AST_W_BUSY: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready))
    else $error("write taken while busy");

  // unmapped writes are refused with an error code
  AST_WR_REFUSE: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && !smo_mapped(st_reg.aw_addr)) |=> s_axi_bresp == SMO_RESP_SLVERR)
    else $error("unmapped write not refused");

  // unmapped reads are refused and return zero
  AST_RD_REFUSE: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && !smo_mapped(s_axi_araddr[13:0]))
    |=> (s_axi_rresp == SMO_RESP_SLVERR && s_axi_rdata == 32'h00000000))
    else $error("unmapped read not refused");

  // only the low byte of a word carries a register
  AST_RD_UPPER: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bytes not zero");
endmodule
`default_nettype wire

// ---- testbench/supply_monitor_osc_regs_test.sv ----
// self-checking bench for the supply monitor, oscillator and regulator registers
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch at %0t: %h vs %h", $time, g, e); end end
module supply_monitor_osc_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  import smo_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready;
  logic awready, wready, arready, abv, sett, isr, mhr, xce, xer, mirq, irq;
  logic [31:0] awaddr, wdata, araddr, rdata, seed;
  logic [3:0] wstrb, vth, mode, ltrim, c;
  logic [1:0] bresp, rresp, ctrim, resp;
  logic [7:0] dat, v;
  int err_total, checks_done, m_en, m_hr, m_vth;

  smo_regs dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .supply_above_threshold_in(abv), .core_supply_settled_in(sett),
    .monitor_high_range(mhr), .monitor_threshold_code(vth), .osc_mode(mode),
    .osc_crystal_enable(xce), .osc_external_ref(xer), .osc_load_trim(ltrim),
    .core_supply_trim(ctrim), .isr_enter(isr), .monitor_irq(mirq), .irq(irq));

  // 50 MHz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // model and bus tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // expected monitor byte; the status bit follows what the bench drives
  function automatic logic [7:0] mon(input logic f);
    return {f, m_en[0], abv, m_hr[0], m_vth[3:0]};
  endfunction

  // both channels offered together, each dropped once taken
  task automatic wr(input logic [13:0] a, input logic [7:0] d, input logic [3:0] s = 4'hf);
    @(posedge aclk);
    awaddr <= {18'h0, a};
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [13:0] a);
    @(posedge aclk);
    araddr <= {18'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    dat = rdata[7:0];
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rc(input logic [13:0] a, input logic [7:0] e);
    rd(a);
    `CHK(dat, e)
    `CHK(resp, SMO_RESP_OKAY)
  endtask

  // supply rises then falls; waits cover the input synchroniser
  task automatic dip();
    abv <= 1'b1;
    repeat (8) @(posedge aclk);
    abv <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    final_report();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h35e1;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, isr, sett} = 7'h0;
    awaddr = 32'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    araddr = 32'h0;
    abv = 1'b1;
    m_en = 0;
    m_hr = 0;
    m_vth = 2;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    rc(SMO_ADDR_MON, 8'h22);
    rc(SMO_ADDR_OSC, 8'hf0);
    `CHK(xer, 1'b0)
    rc(SMO_ADDR_REG, 8'h00);
    // random field values through the monitor, regulator and oscillator registers
    repeat (6) begin
      v = 8'(xs());
      sett <= v[7];
      wr(SMO_ADDR_MON, v & 8'h7f);
      m_en = v[6];
      m_hr = v[4];
      m_vth = v[3:0];
      rc(SMO_ADDR_MON, mon(1'b0));
      `CHK(mhr, v[4])
      `CHK(vth, v[3:0])
      `CHK(mirq, 1'b0)
      wr(SMO_ADDR_REG, v);
      rc(SMO_ADDR_REG, {4'h0, v[3], v[3] | v[7], v[1:0]});
      `CHK(ctrim, v[1:0])
      v = 8'(xs());
      wr(SMO_ADDR_OSC, v);
      `CHK(ltrim, v[3:0])
      `CHK(mode, v[7:4])
      `CHK(xer, v[7:4] == 4'h4)
      `CHK(xce, v[7:4] != 4'h4)
    end
    for (int i = 0; i < 2; i++) begin
      c = i ? SMO_MODE_XTAL : SMO_MODE_EXT;
      wr(SMO_ADDR_OSC, {c, 4'h7});
      `CHK(xce, c == 4'hf)
    end
    // strobe off writes nothing; unmapped place is refused
    wr(SMO_ADDR_OSC, 8'h00, 4'h0);
    rc(SMO_ADDR_OSC, 8'hf7);
    wr(14'h3ffc, 8'hff);
    `CHK(resp, SMO_RESP_SLVERR)
    rd(14'h3ffc);
    `CHK(resp, SMO_RESP_SLVERR)
    `CHK(dat, 8'h00)
    // falling supply with enable set
    m_en = 1;
    wr(SMO_ADDR_MON, mon(1'b0));
    wr(SMO_ADDR_MSK, 8'h01);
    abv <= 1'b0;
    repeat (8) @(posedge aclk);
    `CHK(mirq, 1'b1)
    `CHK(irq, 1'b1)
    rc(SMO_ADDR_MON, mon(1'b1));
    rc(SMO_ADDR_IRQ, 8'h01);
    wr(SMO_ADDR_MON, mon(1'b0));
    rc(SMO_ADDR_MON, mon(1'b1));
    wr(SMO_ADDR_MON, mon(1'b1));
    rc(SMO_ADDR_MON, mon(1'b0));
    `CHK(mirq, 1'b0)
    wr(SMO_ADDR_IRQ, 8'h01);
    `CHK(irq, 1'b0)
    // service-routine entry clears a fresh flag
    dip();
    @(posedge aclk);
    isr <= 1'b1;
    @(posedge aclk);
    isr <= 1'b0;
    repeat (2) @(posedge aclk);
    rc(SMO_ADDR_MON, mon(1'b0));
    // enable off: flag sets but no request
    m_en = 0;
    wr(SMO_ADDR_MON, mon(1'b0));
    dip();
    `CHK(mirq, 1'b0)
    rc(SMO_ADDR_MON, mon(1'b1));
    wr(SMO_ADDR_MSK, 8'h00);
    `CHK(irq, 1'b0)
    final_report();
  end
endmodule
`default_nettype wire
